/* File: rtl/acopl_consts.svh */
`ifndef ACOPL_CONSTS_SVH
`define ACOPL_CONSTS_SVH

// Register offsets.
`define ACOPL_REG_DIV_HI 8'h01
`define ACOPL_REG_DIV_LO 8'h02
`define ACOPL_REG_OFS_R 8'h08
`define ACOPL_REG_TRIM_R 8'h09
`define ACOPL_REG_OFS_G 8'h0a
`define ACOPL_REG_TRIM_G 8'h0b
`define ACOPL_REG_OFS_B 8'h0c
`define ACOPL_REG_TRIM_B 8'h0d
`define ACOPL_REG_CLAMP_POS 8'h19
`define ACOPL_REG_CLAMP_LEN 8'h1a
`define ACOPL_REG_CLAMP_SEL 8'h1b
`define ACOPL_REG_CTRL 8'h1c
`define ACOPL_REG_PLL_CFG 8'h1d
`define ACOPL_REG_CONV_R 8'h2d
`define ACOPL_REG_CONV_G 8'h2e
`define ACOPL_REG_CONV_B 8'h2f
`define ACOPL_REG_STATUS 8'h30

// Field positions.
`define ACOPL_CSEL_RED_BIT 7
`define ACOPL_CSEL_GREEN_BIT 6
`define ACOPL_CSEL_BLUE_BIT 5
`define ACOPL_CTRL_AUTO_BIT 0
`define ACOPL_CTRL_HPOL_BIT 1
`define ACOPL_CTRL_CPOL_BIT 2
`define ACOPL_CTRL_VCOAST_BIT 3
`define ACOPL_CTRL_GSYNC_BIT 4
`define ACOPL_PLLCFG_PHASE_LSB 3
`define ACOPL_DIVLO_LSB 4

// Reset values.
`define ACOPL_DIV_RST 12'h400
`define ACOPL_OFS_RST 8'h40
`define ACOPL_TRIM_RST 7'h00
`define ACOPL_CLAMP_POS_RST 8'h08
`define ACOPL_CLAMP_LEN_RST 8'h14
`define ACOPL_CLAMP_SEL_RST 3'h0
`define ACOPL_CTRL_RST 5'h06
`define ACOPL_BAND_RST 2'h1
`define ACOPL_PHASE_RST 5'h00

// Clamp codes.
`define ACOPL_CLAMP_MID_CODE 8'h80
`define ACOPL_CLAMP_GND_CODE 8'h00

`endif

/* File: rtl/acopl_pkg.sv */
package acopl_pkg;

    typedef enum logic [1:0] {
        CLAMP_IDLE,
        CLAMP_DELAY,
        CLAMP_ON
    } acopl_clamp_state_type;

    typedef struct packed {
        logic auto_en;
        logic clamp_mid;
        logic [7:0] offset;
        logic [6:0] trim;
    } acopl_chan_cfg_type;

    typedef struct packed {
        logic faster;
        logic slower;
        logic feedback;
    } acopl_pll_cmd_type;

endpackage : acopl_pkg

/* File: rtl/acopl_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module acopl_pin_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // A bit moves only when the second and third stages agree, so a lone glitch is dropped.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    q[i] <= s3_r[i];
                end
            end
        end
    end

endmodule : acopl_pin_sync

`default_nettype wire

/* File: rtl/acopl_offset_loop.sv */
`timescale 1ns/1ps
`default_nettype none
`include "acopl_consts.svh"

module acopl_offset_loop (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clamp,
    input wire acopl_pkg::acopl_chan_cfg_type cfg,
    input wire logic [7:0] adc_code,
    output logic [7:0] conv_offset,
    output logic [7:0] clamp_code
);

    logic clamp_d_r;
    logic below_r;
    logic above_r;
    logic [7:0] auto_r;
    logic [7:0] base;

    function automatic logic [7:0] sat_add(input logic [7:0] b, input logic [6:0] t);
        logic signed [9:0] sum;
        sum = $signed({2'b00, b}) + $signed({{3{t[6]}}, t});
        if (sum < 0) begin
            sat_add = 8'h00;
        end else if (sum > 10'sd255) begin
            sat_add = 8'hff;
        end else begin
            sat_add = sum[7:0];
        end
    endfunction : sat_add

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clamp_d_r <= 1'b0;
            below_r <= 1'b0;
            above_r <= 1'b0;
        end else begin
            clamp_d_r <= clamp;
            if (clamp) begin
                // While enabled the offset field is the wanted clamp code. see RQ3
                below_r <= adc_code < cfg.offset; // see RQ4
                above_r <= adc_code > cfg.offset; // see RQ4
            end
        end
    end

    // One step at the close of each clamp interval keeps the loop slow and free of hunting.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            auto_r <= `ACOPL_OFS_RST;
        end else if (cfg.auto_en && clamp_d_r && !clamp) begin // see RQ5
            if (below_r && auto_r != 8'hff) begin
                auto_r <= auto_r + 8'h01; // see RQ19
            end else if (above_r && auto_r != 8'h00) begin
                auto_r <= auto_r - 8'h01; // see RQ19
            end
        end
    end

    assign base = cfg.auto_en ? auto_r : cfg.offset;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_offset <= `ACOPL_OFS_RST;
            clamp_code <= `ACOPL_CLAMP_GND_CODE;
        end else begin
            conv_offset <= sat_add(base, cfg.trim); // see RQ7 see RQ8 see RQ19
            clamp_code <= cfg.clamp_mid ? `ACOPL_CLAMP_MID_CODE : `ACOPL_CLAMP_GND_CODE; // see RQ2
        end
    end

endmodule : acopl_offset_loop

`default_nettype wire

/* File: rtl/acopl_ctrl.sv */
// What this block does
// RQ1 - Bits 7:5 of clamp select choose midscale or ground per converter.
// RQ2 - Midscale clamps to code 128, ground clamps to code 0.
// RQ3 - With auto offset on, the offset register is the wanted clamp code.
// RQ4 - Auto offset steps up when output is below target, down when above.
// RQ5 - Auto offset updates each clamp interval and holds in between.
// RQ6 - Red, green and blue offset registers sit at three addresses.
// RQ7 - Offset trim is two's complement, plus or minus 64 steps.
// RQ8 - Converter offset is the computed offset plus the channel trim.
// RQ9 - Green channel sync is always active low, whatever the polarity bits.
// RQ10 - Pixel clock is divided by the two-register divisor and compared to line sync.
// RQ11 - The divisor is twelve bits and sets pixel to line frequency ratio.
// RQ12 - Two-bit band picks one of four oscillator ranges.
// RQ13 - Five-bit phase shifts sampling in 32 steps of 11.25 degrees.
// RQ14 - The aligned line sync output gets the same phase shift.
// RQ15 - During hold the loop keeps its frequency and ignores line sync.
// RQ16 - Polarity bits for line sync and hold treat 1 as active high.
// RQ17 - Internal hold comes from vertical sync.
// RQ18 - Clamp starts a programmed delay after the sync trailing edge, lasts a count.
// RQ19 - Auto offset moves one step per interval; summed offset saturates.
`timescale 1ns/1ps
`default_nettype none
`include "acopl_consts.svh"

module acopl_ctrl (
    // Clock and reset.
    input wire logic MCLK,
    input wire logic RESETN,
    // Register port.
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // Sync pins.
    input wire logic LINE_SYNC_IN,
    input wire logic GREEN_CHANNEL_SYNC,
    input wire logic FRAME_SYNC_IN,
    input wire logic HOLD_FREQ_IN,
    // Converters.
    input wire logic [23:0] ADC_CODE,
    output logic [23:0] CONV_OFFSET,
    output logic [23:0] CLAMP_CODE,
    output logic CLAMP_ACTIVE,
    // Pixel clock loop.
    output logic PLL_FASTER,
    output logic PLL_SLOWER,
    output logic PLL_FEEDBACK,
    output logic [1:0] OSCILLATOR_BAND,
    output logic [4:0] SAMPLING_PHASE,
    output logic ALIGNED_LINE_SYNC_OUT
);

    logic rst_s1_r;
    logic rst_n;

    logic [11:0] div_r;
    logic [7:0] ofs_r [3];
    logic [6:0] trim_r [3];
    logic [7:0] clamp_pos_r;
    logic [7:0] clamp_len_r;
    logic [2:0] clamp_sel_r;
    logic [4:0] ctrl_r;
    logic [1:0] band_r;
    logic [4:0] phase_r;

    logic [3:0] pins_q;
    logic line_active;
    logic line_d_r;
    logic line_lead;
    logic line_trail;
    logic hold_active;

    acopl_pkg::acopl_clamp_state_type cstate_r;
    logic [7:0] ccnt_r;

    logic [11:0] fb_cnt_r;
    acopl_pkg::acopl_pll_cmd_type pll_r;
    logic [31:0] sync_dly_r;

    logic [7:0] conv [3];

    // Reset is applied at once and released only after two clock edges.
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_s1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n <= rst_s1_r;
        end
    end

    // Register writes.
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= `ACOPL_DIV_RST;
            clamp_pos_r <= `ACOPL_CLAMP_POS_RST;
            clamp_len_r <= `ACOPL_CLAMP_LEN_RST;
            clamp_sel_r <= `ACOPL_CLAMP_SEL_RST;
            ctrl_r <= `ACOPL_CTRL_RST;
            band_r <= `ACOPL_BAND_RST;
            phase_r <= `ACOPL_PHASE_RST;
            for (int i = 0; i < 3; i++) begin
                ofs_r[i] <= `ACOPL_OFS_RST;
                trim_r[i] <= `ACOPL_TRIM_RST;
            end
        end else if (REG_WR) begin
            case (REG_ADDR)
                `ACOPL_REG_DIV_HI: div_r[11:4] <= REG_WDATA; // see RQ10 see RQ11
                `ACOPL_REG_DIV_LO: div_r[3:0] <= REG_WDATA[`ACOPL_DIVLO_LSB +: 4]; // see RQ11
                `ACOPL_REG_OFS_R: ofs_r[0] <= REG_WDATA; // see RQ6
                `ACOPL_REG_OFS_G: ofs_r[1] <= REG_WDATA; // see RQ6
                `ACOPL_REG_OFS_B: ofs_r[2] <= REG_WDATA; // see RQ6
                `ACOPL_REG_TRIM_R: trim_r[0] <= REG_WDATA[6:0];
                `ACOPL_REG_TRIM_G: trim_r[1] <= REG_WDATA[6:0];
                `ACOPL_REG_TRIM_B: trim_r[2] <= REG_WDATA[6:0];
                `ACOPL_REG_CLAMP_POS: clamp_pos_r <= REG_WDATA;
                `ACOPL_REG_CLAMP_LEN: clamp_len_r <= REG_WDATA;
                `ACOPL_REG_CLAMP_SEL: clamp_sel_r <= REG_WDATA[7:5]; // see RQ1
                `ACOPL_REG_CTRL: ctrl_r <= REG_WDATA[4:0];
                `ACOPL_REG_PLL_CFG: begin
                    band_r <= REG_WDATA[1:0]; // see RQ12
                    phase_r <= REG_WDATA[`ACOPL_PLLCFG_PHASE_LSB +: 5]; // see RQ13
                end
                default: begin
                end
            endcase
        end
    end

    // Register reads answer one cycle after the strobe; unmapped addresses read zero.
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD) begin
            case (REG_ADDR)
                `ACOPL_REG_DIV_HI: REG_RDATA <= div_r[11:4];
                `ACOPL_REG_DIV_LO: REG_RDATA <= {div_r[3:0], 4'h0};
                `ACOPL_REG_OFS_R: REG_RDATA <= ofs_r[0];
                `ACOPL_REG_OFS_G: REG_RDATA <= ofs_r[1];
                `ACOPL_REG_OFS_B: REG_RDATA <= ofs_r[2];
                `ACOPL_REG_TRIM_R: REG_RDATA <= {1'b0, trim_r[0]};
                `ACOPL_REG_TRIM_G: REG_RDATA <= {1'b0, trim_r[1]};
                `ACOPL_REG_TRIM_B: REG_RDATA <= {1'b0, trim_r[2]};
                `ACOPL_REG_CLAMP_POS: REG_RDATA <= clamp_pos_r;
                `ACOPL_REG_CLAMP_LEN: REG_RDATA <= clamp_len_r;
                `ACOPL_REG_CLAMP_SEL: REG_RDATA <= {clamp_sel_r, 5'h00};
                `ACOPL_REG_CTRL: REG_RDATA <= {3'h0, ctrl_r};
                `ACOPL_REG_PLL_CFG: REG_RDATA <= {phase_r, 1'b0, band_r};
                `ACOPL_REG_CONV_R: REG_RDATA <= conv[0];
                `ACOPL_REG_CONV_G: REG_RDATA <= conv[1];
                `ACOPL_REG_CONV_B: REG_RDATA <= conv[2];
                `ACOPL_REG_STATUS: REG_RDATA <= {5'h00, hold_active, line_active, CLAMP_ACTIVE};
                default: REG_RDATA <= 8'h00;
            endcase
        end
    end

    acopl_pin_sync #(
        .W(4)
    ) u_pins (
        .clk(MCLK),
        .rst_n(rst_n),
        .d({HOLD_FREQ_IN, FRAME_SYNC_IN, GREEN_CHANNEL_SYNC, LINE_SYNC_IN}),
        .q(pins_q)
    );

    // Green sync ignores the polarity bit and is taken as active low.
    always_comb begin
        if (ctrl_r[`ACOPL_CTRL_GSYNC_BIT]) begin
            line_active = ~pins_q[1]; // see RQ9
        end else if (ctrl_r[`ACOPL_CTRL_HPOL_BIT]) begin
            line_active = pins_q[0]; // see RQ16
        end else begin
            line_active = ~pins_q[0]; // see RQ16
        end
    end

    // Hold comes from the pin at its programmed polarity or from frame sync.
    assign hold_active = (ctrl_r[`ACOPL_CTRL_CPOL_BIT] ? pins_q[3] : ~pins_q[3]) // see RQ16
        | (ctrl_r[`ACOPL_CTRL_VCOAST_BIT] & pins_q[2]); // see RQ17

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            line_d_r <= 1'b0;
        end else begin
            line_d_r <= line_active;
        end
    end

    assign line_lead = line_active & ~line_d_r;
    assign line_trail = ~line_active & line_d_r;

    // Clamp timing: delay then duration, both in pixel periods from the sync trailing edge.
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            cstate_r <= acopl_pkg::CLAMP_IDLE;
            ccnt_r <= 8'h00;
        end else if (line_trail) begin
            cstate_r <= acopl_pkg::CLAMP_DELAY; // see RQ18
            ccnt_r <= 8'h00;
        end else begin
            case (cstate_r)
                acopl_pkg::CLAMP_IDLE: begin
                    ccnt_r <= 8'h00;
                end
                acopl_pkg::CLAMP_DELAY: begin
                    if (ccnt_r >= clamp_pos_r) begin // see RQ18
                        cstate_r <= (clamp_len_r == 8'h00) ? acopl_pkg::CLAMP_IDLE
                            : acopl_pkg::CLAMP_ON;
                        ccnt_r <= 8'h00;
                    end else begin
                        ccnt_r <= ccnt_r + 8'h01;
                    end
                end
                acopl_pkg::CLAMP_ON: begin
                    if (ccnt_r + 8'h01 >= clamp_len_r) begin // see RQ18
                        cstate_r <= acopl_pkg::CLAMP_IDLE;
                        ccnt_r <= 8'h00;
                    end else begin
                        ccnt_r <= ccnt_r + 8'h01;
                    end
                end
                default: begin
                    cstate_r <= acopl_pkg::CLAMP_IDLE;
                    ccnt_r <= 8'h00;
                end
            endcase
        end
    end

    assign CLAMP_ACTIVE = (cstate_r == acopl_pkg::CLAMP_ON);

    for (genvar c = 0; c < 3; c++) begin : g_chan
        acopl_pkg::acopl_chan_cfg_type cfg;

        assign cfg.auto_en = ctrl_r[`ACOPL_CTRL_AUTO_BIT];
        assign cfg.clamp_mid = clamp_sel_r[2 - c]; // see RQ1
        assign cfg.offset = ofs_r[c];
        assign cfg.trim = trim_r[c];

        acopl_offset_loop u_loop (
            .clk(MCLK),
            .rst_n(rst_n),
            .clamp(CLAMP_ACTIVE),
            .cfg(cfg),
            .adc_code(ADC_CODE[23 - 8 * c -: 8]),
            .conv_offset(conv[c]),
            .clamp_code(CLAMP_CODE[23 - 8 * c -: 8])
        );

        assign CONV_OFFSET[23 - 8 * c -: 8] = conv[c];
    end

    // Feedback divider on the pixel clock; a zero divisor wraps as the largest count.
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            fb_cnt_r <= 12'h000;
        end else if (fb_cnt_r >= div_r - 12'h001) begin // see RQ10 see RQ11
            fb_cnt_r <= 12'h000;
        end else begin
            fb_cnt_r <= fb_cnt_r + 12'h001;
        end
    end

    // Phase compare at each line sync leading edge outside hold; the count position is the error.
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            pll_r <= '0;
        end else begin
            pll_r.feedback <= (fb_cnt_r == 12'h000);
            pll_r.faster <= 1'b0;
            pll_r.slower <= 1'b0;
            if (line_lead && !hold_active) begin // see RQ15
                pll_r.faster <= fb_cnt_r >= {1'b0, div_r[11:1]}; // see RQ10
                pll_r.slower <= fb_cnt_r != 12'h000 && fb_cnt_r < {1'b0, div_r[11:1]}; // see RQ10
            end
        end
    end

    assign PLL_FASTER = pll_r.faster;
    assign PLL_SLOWER = pll_r.slower;
    assign PLL_FEEDBACK = pll_r.feedback;
    assign OSCILLATOR_BAND = band_r; // see RQ12
    assign SAMPLING_PHASE = phase_r; // see RQ13

    // Each phase step delays the aligned sync by one clock, mirroring the sampling delay.
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            sync_dly_r <= 32'h0000_0000;
            ALIGNED_LINE_SYNC_OUT <= 1'b0;
        end else begin
            sync_dly_r <= {sync_dly_r[30:0], line_active};
            ALIGNED_LINE_SYNC_OUT <= sync_dly_r[phase_r]; // see RQ14
        end
    end

endmodule : acopl_ctrl

`default_nettype wire

/* File: verif/acopl_source_model.sv */
`timescale 1ns/1ps
`default_nettype none

module acopl_source_model #(
    parameter logic [7:0] BLACK = 8'h3c
) (
    // Clock and run control.
    input wire logic clk,
    input wire logic en,
    // Offset fed back from the device.
    input wire logic [23:0] conv_offset,
    // Video and sync towards the device.
    output logic line_sync,
    output logic green_sync,
    output logic [23:0] adc_code
);
    logic [5:0] pos = 6'h00;

    initial line_sync = 1'b0;

    // A line is 64 clocks with an 8-clock sync at its start; when stopped, sync rests inactive.
    always @(posedge clk) begin
        pos <= pos + 6'h01;
        line_sync <= en && (pos < 6'h08);
    end

    assign green_sync = ~line_sync;

    // The black level rises with the converter offset, which closes the offset loop.
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            adc_code[i * 8 +: 8] = conv_offset[i * 8 +: 8] - BLACK;
        end
    end
endmodule : acopl_source_model

`default_nettype wire

/* File: verif/acopl_ctrl_props.sv */
`timescale 1ns/1ps
`default_nettype none

module acopl_ctrl_props (
    // Clock and reset.
    input wire logic MCLK,
    input wire logic RESETN,
    // Register port.
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    // Outputs watched.
    input wire logic [23:0] CONV_OFFSET,
    input wire logic [23:0] CLAMP_CODE,
    input wire logic CLAMP_ACTIVE,
    input wire logic PLL_FASTER,
    input wire logic PLL_SLOWER,
    input wire logic PLL_FEEDBACK,
    input wire logic [1:0] OSCILLATOR_BAND,
    input wire logic [4:0] SAMPLING_PHASE
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RESETN);

    chk_clamp_levels: assert property ((CLAMP_CODE & 24'h7f7f7f) == 24'h000000)
        else $error("clamp code is neither midscale nor ground");
    chk_clamp_sel_src: assert property ($changed(CLAMP_CODE) |->
        ($past(REG_WR) && $past(REG_ADDR) == 8'h1b)
        || ($past(REG_WR, 2) && $past(REG_ADDR, 2) == 8'h1b))
        else $error("clamp code changed without a clamp select write");
    chk_band_write_only: assert property ($changed(OSCILLATOR_BAND) |->
        $past(REG_WR) && $past(REG_ADDR) == 8'h1d)
        else $error("band changed without a write");
    chk_phase_from_write: assert property (REG_WR && REG_ADDR == 8'h1d |=>
        SAMPLING_PHASE == $past(REG_WDATA[7:3]))
        else $error("phase does not follow the written field");
    chk_feedback_pulse: assert property (PLL_FEEDBACK |=> !PLL_FEEDBACK)
        else $error("feedback pulse longer than one cycle");
    chk_dir_exclusive: assert property (!(PLL_FASTER && PLL_SLOWER))
        else $error("faster and slower together");
    // Writes reach the offset within three cycles and a clamp end within four.
    chk_offset_held: assert property ($changed(CONV_OFFSET) |->
        $past(REG_WR) || $past(REG_WR, 2) || $past(REG_WR, 3) || $past(CLAMP_ACTIVE, 2)
        || $past(CLAMP_ACTIVE, 3) || $past(CLAMP_ACTIVE, 4))
        else $error("offset moved outside clamp and writes");
    chk_offset_one_step: assert property ($changed(CONV_OFFSET) && !$past(REG_WR)
        && !$past(REG_WR, 2) && !$past(REG_WR, 3) |->
        (CONV_OFFSET[23:16] - $past(CONV_OFFSET[23:16])) inside {8'h00, 8'h01, 8'hff})
        else $error("auto offset moved more than one step");

    cov_clamp_end: cover property ($fell(CLAMP_ACTIVE));
    cov_faster: cover property (PLL_FASTER);
    cov_slower: cover property (PLL_SLOWER);
endmodule : acopl_ctrl_props

bind acopl_ctrl acopl_ctrl_props u_props (
    .MCLK(MCLK), .RESETN(RESETN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .CONV_OFFSET(CONV_OFFSET), .CLAMP_CODE(CLAMP_CODE),
    .CLAMP_ACTIVE(CLAMP_ACTIVE), .PLL_FASTER(PLL_FASTER), .PLL_SLOWER(PLL_SLOWER),
    .PLL_FEEDBACK(PLL_FEEDBACK), .OSCILLATOR_BAND(OSCILLATOR_BAND),
    .SAMPLING_PHASE(SAMPLING_PHASE)
);

`default_nettype wire

/* File: verif/acopl_ctrl_test.sv */
`timescale 1ns/1ps
`default_nettype none

module acopl_ctrl_test;
    logic MCLK = 1'b0;
    logic RESETN = 1'b0;
    logic [7:0] REG_ADDR = 8'h00;
    logic [7:0] REG_WDATA = 8'h00;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic FRAME_SYNC_IN = 1'b0;
    logic HOLD_FREQ_IN = 1'b0;
    logic src_en = 1'b0;
    logic LINE_SYNC_IN, GREEN_CHANNEL_SYNC, CLAMP_ACTIVE, ALIGNED_LINE_SYNC_OUT;
    logic PLL_FASTER, PLL_SLOWER, PLL_FEEDBACK;
    logic [7:0] REG_RDATA;
    logic [23:0] ADC_CODE, CONV_OFFSET, CLAMP_CODE;
    logic [1:0] OSCILLATOR_BAND;
    logic [4:0] SAMPLING_PHASE;
    wire [3:0] mon = {ALIGNED_LINE_SYNC_OUT, CLAMP_ACTIVE, PLL_FASTER | PLL_SLOWER, PLL_FEEDBACK};
    int n_fail = 0;
    int tests_run = 0;
    int n, d0, d1;
    // Address, reset value, value written, value read back; divisor ends at 79.
    // The red converter offset readback ignores writes and shows the manual offset.
    logic [31:0] rows [12] = '{32'h01400404, 32'h0200f0f0, 32'h08401010, 32'h0a401010,
        32'h0c401010, 32'h19080000, 32'h1a140404, 32'h1b00e0e0, 32'h1c060606,
        32'h1d010202, 32'h2d105a10, 32'h40005a00};
    // Control value, hold pin, frame sync pin, speed pulses expected.
    logic [11:0] pll_rows [4] = '{12'h071, 12'h074, 12'h035, 12'h0f2};

    acopl_ctrl DUT (
        .MCLK(MCLK), .RESETN(RESETN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .LINE_SYNC_IN(LINE_SYNC_IN), .GREEN_CHANNEL_SYNC(GREEN_CHANNEL_SYNC),
        .FRAME_SYNC_IN(FRAME_SYNC_IN), .HOLD_FREQ_IN(HOLD_FREQ_IN), .ADC_CODE(ADC_CODE),
        .CONV_OFFSET(CONV_OFFSET), .CLAMP_CODE(CLAMP_CODE), .CLAMP_ACTIVE(CLAMP_ACTIVE),
        .PLL_FASTER(PLL_FASTER), .PLL_SLOWER(PLL_SLOWER), .PLL_FEEDBACK(PLL_FEEDBACK),
        .OSCILLATOR_BAND(OSCILLATOR_BAND), .SAMPLING_PHASE(SAMPLING_PHASE),
        .ALIGNED_LINE_SYNC_OUT(ALIGNED_LINE_SYNC_OUT)
    );

    acopl_source_model u_src (
        .clk(MCLK), .en(src_en), .conv_offset(CONV_OFFSET), .line_sync(LINE_SYNC_IN),
        .green_sync(GREEN_CHANNEL_SYNC), .adc_code(ADC_CODE)
    );

    initial begin
        forever #2.5 MCLK = ~MCLK;
    end

    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            n_fail++;
        end
    endtask : chk

    task automatic rst;
        @(posedge MCLK);
        RESETN <= 1'b0;
        repeat (2) @(posedge MCLK);
        RESETN <= 1'b1;
        repeat (3) @(posedge MCLK);
    endtask : rst

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge MCLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge MCLK);
        REG_WR <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge MCLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge MCLK);
        REG_RD <= 1'b0;
        @(posedge MCLK);
        #1;
        chk("register read", 24'(exp), 24'(REG_RDATA));
    endtask : rd

    // Counts rising edges of one monitored signal over a fixed window.
    task automatic cnt(input int b, input int cyc, output int k);
        logic p;
        k = 0;
        p = 1'b0;
        repeat (cyc) begin
            @(posedge MCLK);
            #1;
            if (mon[b] === 1'b1 && p !== 1'b1) k++;
            p = mon[b];
        end
    endtask : cnt

    // Clocks from a line sync edge until a monitored output rises; a full line settles first.
    task automatic dly(input logic fall, output int d);
        d = 0;
        repeat (64) @(posedge MCLK);
        if (fall) @(negedge LINE_SYNC_IN);
        else @(posedge LINE_SYNC_IN);
        while (mon[fall ? 2 : 3] !== 1'b1 && d < 60) begin
            @(posedge MCLK);
            #1;
            d++;
        end
    endtask : dly

    task automatic finish_test;
        if (n_fail == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    initial begin
        #300us;
        n_fail++;
        finish_test();
    end

    initial begin
        rst();
        foreach (rows[i]) begin
            rd(rows[i][31:24], rows[i][23:16]);
            wr(rows[i][31:24], rows[i][15:8]);
            rd(rows[i][31:24], rows[i][7:0]);
        end
        chk("clamp code", 24'h808080, CLAMP_CODE);
        chk("manual offset", 24'h101010, CONV_OFFSET);
        chk("band", 24'h000002, 24'(OSCILLATOR_BAND));
        for (int i = 0; i < 3; i++) begin
            wr(8'h1b, 8'h80 >> i);
            repeat (3) @(posedge MCLK);
            chk("clamp code", 24'h800000 >> (8 * i), CLAMP_CODE);
        end
        wr(8'h08, 8'hf0);
        wr(8'h09, 8'h20);
        wr(8'h0b, 8'h76);
        wr(8'h0d, 8'h40);
        repeat (3) @(posedge MCLK);
        chk("saturated offset", 24'hff0600, CONV_OFFSET);
        wr(8'h08, 8'h10);
        for (int a = 9; a < 14; a += 2) begin
            wr(8'(a), 8'h00);
        end
        wr(8'h1c, 8'h07);
        src_en <= 1'b1;
        repeat (2600) @(posedge MCLK);
        chk("auto offset", 24'h4c4c4c, CONV_OFFSET);
        src_en <= 1'b0;
        repeat (100) @(posedge MCLK);
        wr(8'h09, 8'h0a);
        repeat (200) @(posedge MCLK);
        chk("trimmed auto offset", 24'h564c4c, CONV_OFFSET);
        wr(8'h09, 8'h00);
        src_en <= 1'b1;
        cnt(0, 790, n);
        chk("feedback pulses", 24'd10, 24'(n));
        foreach (pll_rows[i]) begin
            wr(8'h1c, pll_rows[i][11:4]);
            HOLD_FREQ_IN <= pll_rows[i][2];
            FRAME_SYNC_IN <= pll_rows[i][1];
            repeat (10) @(posedge MCLK);
            cnt(1, 640, n);
            chk("speed pulses", 24'(pll_rows[i][0]), 24'(n > 0));
        end
        wr(8'h1c, 8'h06);
        FRAME_SYNC_IN <= 1'b0;
        HOLD_FREQ_IN <= 1'b0;
        wr(8'h1d, 8'h02);
        dly(1'b0, d0);
        wr(8'h1d, 8'h3a);
        dly(1'b0, d1);
        chk("phase delay step", 24'd7, 24'(d1 - d0));
        dly(1'b1, d0);
        wr(8'h1c, 8'h14);
        dly(1'b1, d1);
        chk("green sync clamp delay", 24'(d0), 24'(d1));
        wr(8'h1c, 8'h04);
        dly(1'b1, d1);
        chk("line polarity", 24'h000001, 24'(d1 != d0));
        rst();
        rd(8'h1b, 8'h00);
        chk("offset after reset", 24'h404040, CONV_OFFSET);
        finish_test();
    end
endmodule : acopl_ctrl_test

`default_nettype wire
